// ===== verilog/ohc_cfg_map.svh
// Purpose: Offsets, field positions and reset values of the OHCI config header block
// Assumes: Configuration space is seen as 32-bit dwords, index = byte offset / 4
// Notes:   Definitions only, no logic
`ifndef OHC_CFG_MAP_SVH
`define OHC_CFG_MAP_SVH

// ==========================================================================
// Printed byte offsets
`define OHC_OFS_LATGNT 8'h3e
`define OHC_OFS_CTRL 8'h40
`define OHC_OFS_CAP 8'h44

// ==========================================================================
// Dword indices of the words holding each register
`define OHC_DW_LATGNT 6'h0f
`define OHC_DW_CTRL 6'h10
`define OHC_DW_CAP 6'h11

// Lane placement of the 16-bit registers inside their dword
`define OHC_LATGNT_LSB 16
`define OHC_CAP_LSB 0

// ==========================================================================
// Latency / grant request register
`define OHC_LATGNT_RST 16'h0402
`define OHC_LAT_NIB_LSB 8
`define OHC_GNT_NIB_LSB 0

// ==========================================================================
// Endian control register
`define OHC_SWAP_BIT 0
`define OHC_SWAP_RST 1'h0
`define OHC_SWAP_BE 0

// ==========================================================================
// Capability list header
`define OHC_CAP_NEXT 8'h00
`define OHC_CAP_CODE 8'h01

`endif

// ===== verilog/ohc_cfg_pkg.sv
// Purpose: Types shared by the OHCI config header block
// Assumes: Offsets and values live in ohc_cfg_map.svh
// Notes:   Structs carry the config port and the quadlet paths
`default_nettype none

package ohc_cfg_pkg;

    // ======================================================================
    // Configuration access from the host
    typedef struct packed {
        logic valid;         // One-cycle request strobe
        logic write;         // 1 = write, 0 = read
        logic [5:0] dword;   // Dword index in config space
        logic [3:0] be;      // Byte enables, active high
        logic [31:0] wdata;  // Write data
    } ohc_cfg_req_s;

    // Answer to a configuration access
    typedef struct packed {
        logic ack;           // One-cycle answer strobe
        logic [31:0] rdata;  // Read data, zero for writes
    } ohc_cfg_rsp_s;

    // One quadlet on a data path
    typedef struct packed {
        logic valid;         // Quadlet present this cycle
        logic [31:0] data;   // Quadlet value
    } ohc_quad_s;

    // EEPROM load window
    typedef enum logic {
        LOAD_OPEN,
        LOAD_CLOSED
    } ohc_load_e;

endpackage : ohc_cfg_pkg

`default_nettype wire

// ===== verilog/ohc_byte_swap.sv
// Purpose: Optional byte reversal of one word
// Assumes: Width is a whole number of bytes
// Notes:   Pure combinational, caller registers the result
`default_nettype none

module ohc_byte_swap #(
    parameter int WIDTH = 32
) (
    input wire logic enable,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    // ======================================================================
    // Elaboration check
    localparam int NBYTES = WIDTH / 8;

    generate
        if ((WIDTH % 8) != 0 || WIDTH < 8) begin : g_bad_width
            $error("ohc_byte_swap: WIDTH must be a multiple of 8");
        end
    endgenerate

    // ======================================================================
    // Byte reversal
    logic [WIDTH-1:0] swapped; // Bytes in reversed order

    genvar gi;
    generate
        for (gi = 0; gi < NBYTES; gi++) begin : g_lane
            assign swapped[gi*8 +: 8] = din[(NBYTES-1-gi)*8 +: 8];
        end
    endgenerate

    // Select swapped or straight word
    assign dout = enable ? swapped : din;

endmodule : ohc_byte_swap

`default_nettype wire

// ===== verilog/ohc_cfg_regs.sv
// Purpose: Latency/grant request, endian control and capability header registers
// Assumes: reset is the global reset; function_reset is a lesser, synchronous reset
// Notes:   Quadlet paths to and from the bus are byte-swapped by the control bit
`include "ohc_cfg_map.svh"
`default_nettype none

module ohc_cfg_regs
    import ohc_cfg_pkg::*;
#(
    parameter int QUAD_W = 32
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic function_reset,
    input wire ohc_cfg_req_s cfg_req,
    output ohc_cfg_rsp_s cfg_rsp,
    input wire logic eeprom_present,
    input wire logic ee_load_valid,
    input wire logic [3:0] ee_lat_nibble,
    input wire logic [3:0] ee_gnt_nibble,
    input wire logic ee_load_done,
    input wire ohc_quad_s bus_in_quad,
    output ohc_quad_s core_out_quad,
    input wire ohc_quad_s core_in_quad,
    output ohc_quad_s bus_out_quad,
    output logic [15:0] latency_grant_request,
    output logic swap_enable,
    output logic load_open
);

    // ======================================================================
    // Elaboration check
    generate
        if (QUAD_W != 32) begin : g_bad_quad
            $error("ohc_cfg_regs: quadlet paths must be 32 bits wide");
        end
    endgenerate

    // ======================================================================
    // EEPROM load window
    ohc_load_e load_q; // Window state
    ohc_load_e load_d; // Next window state
    logic load_open_q; // Registered window-open flag
    logic load_open_d; // Next window-open flag

    // Window opens at global reset, closes when loader ends or is absent
    always_comb begin
        load_d = load_q;
        unique case (load_q)
            LOAD_OPEN: begin
                // No EEPROM: keep default, never load
                if (!eeprom_present) begin
                    load_d = LOAD_CLOSED;
                end else if (ee_load_done) begin
                    load_d = LOAD_CLOSED;
                end
            end
            LOAD_CLOSED: begin
                load_d = LOAD_CLOSED;
            end
        endcase
        // Flag mirrors the next state so the output leaves a flop
        load_open_d = (load_d == LOAD_OPEN);
    end

    // Window register, only global reset reopens it
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            load_q <= LOAD_OPEN;
            load_open_q <= 1'b1;
        end else begin
            load_q <= load_d;
            load_open_q <= load_open_d;
        end
    end

    // ======================================================================
    // Latency / grant request register
    logic [3:0] lat_nib_q; // Loadable latency nibble
    logic [3:0] lat_nib_d; // Next latency nibble
    logic [3:0] gnt_nib_q; // Loadable grant nibble
    logic [3:0] gnt_nib_d; // Next grant nibble
    logic [15:0] latgnt_value; // Assembled register value
    // Reset image, a constant so the async reset branch loads constants only
    localparam logic [15:0] latgnt_rst = `OHC_LATGNT_RST;

    // Load nibbles from EEPROM while the window is open
    always_comb begin
        lat_nib_d = lat_nib_q;
        gnt_nib_d = gnt_nib_q;
        // Host writes never reach here
        if (load_q == LOAD_OPEN && eeprom_present && ee_load_valid) begin
            lat_nib_d = ee_lat_nibble;
            gnt_nib_d = ee_gnt_nibble;
        end
    end

    // Nibble registers, cleared to default by global reset alone
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            lat_nib_q <= latgnt_rst[`OHC_LAT_NIB_LSB +: 4];
            gnt_nib_q <= latgnt_rst[`OHC_GNT_NIB_LSB +: 4];
        end else begin
            lat_nib_q <= lat_nib_d; // Function reset has no effect
            gnt_nib_q <= gnt_nib_d;
        end
    end

    // Upper nibbles fixed at their defaults
    always_comb begin
        latgnt_value = latgnt_rst;
        latgnt_value[`OHC_LAT_NIB_LSB +: 4] = lat_nib_q;
        latgnt_value[`OHC_GNT_NIB_LSB +: 4] = gnt_nib_q;
    end

    // ======================================================================
    // Endian control register
    logic swap_q; // Byte-swap control
    logic swap_d; // Next byte-swap control
    logic ctrl_wr; // Host write hitting the control lane

    assign ctrl_wr = cfg_req.valid && cfg_req.write && (cfg_req.dword == `OHC_DW_CTRL)
                     && cfg_req.be[`OHC_SWAP_BE]; // Only writable lane

    // Host write sets or clears; function reset returns it to little endian
    always_comb begin
        swap_d = swap_q;
        if (function_reset) begin
            swap_d = `OHC_SWAP_RST;
        end else if (ctrl_wr) begin
            swap_d = cfg_req.wdata[`OHC_SWAP_BIT];
        end
    end

    // Control register
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            swap_q <= `OHC_SWAP_RST;
        end else begin
            swap_q <= swap_d;
        end
    end

    // ======================================================================
    // Configuration read mux
    logic [31:0] rd_word; // Read data for the addressed dword
    logic [15:0] cap_hdr; // Capability list header

    // Header is constant: end of list, power-management code
    assign cap_hdr = {`OHC_CAP_NEXT, `OHC_CAP_CODE};

    // Select the addressed dword; unmapped dwords read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (cfg_req.dword)
            `OHC_DW_LATGNT: begin
                // Interrupt line/pin lanes stay zero
                rd_word[`OHC_LATGNT_LSB +: 16] = latgnt_value;
            end
            `OHC_DW_CTRL: begin
                // Reserved bits above the swap bit
                rd_word[`OHC_SWAP_BIT] = swap_q;
            end
            `OHC_DW_CAP: begin
                // Power-management capabilities lanes stay zero
                rd_word[`OHC_CAP_LSB +: 16] = cap_hdr;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // ======================================================================
    // Configuration answer
    ohc_cfg_rsp_s rsp_q; // Registered answer
    ohc_cfg_rsp_s rsp_d; // Next answer

    // One-cycle ack per request; writes elsewhere only acknowledged
    always_comb begin
        rsp_d.ack = cfg_req.valid;
        rsp_d.rdata = 32'h0000_0000;
        if (cfg_req.valid && !cfg_req.write) begin
            rsp_d.rdata = rd_word;
        end
        // Writes to read-only words fall through with no side effect
    end

    // Answer register
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    // ======================================================================
    // Quadlet byte-swap paths
    logic [31:0] in_swapped; // Bus-to-core quadlet after swap
    logic [31:0] out_swapped; // Core-to-bus quadlet after swap

    // Inbound quadlets from the bus
    ohc_byte_swap #(
        .WIDTH(QUAD_W)
    ) u_swap_in (
        .enable(swap_q),
        .din(bus_in_quad.data),
        .dout(in_swapped)
    );

    // Outbound quadlets to the bus
    ohc_byte_swap #(
        .WIDTH(QUAD_W)
    ) u_swap_out (
        .enable(swap_q),
        .din(core_in_quad.data),
        .dout(out_swapped)
    );

    ohc_quad_s core_q; // Registered inbound quadlet
    ohc_quad_s core_d; // Next inbound quadlet
    ohc_quad_s bus_q; // Registered outbound quadlet
    ohc_quad_s bus_d; // Next outbound quadlet

    // Both directions swapped by the same control bit
    always_comb begin
        core_d.valid = bus_in_quad.valid;
        core_d.data = bus_in_quad.valid ? in_swapped : core_q.data;
        bus_d.valid = core_in_quad.valid;
        bus_d.data = core_in_quad.valid ? out_swapped : bus_q.data;
    end

    // Path registers, one cycle of latency each way
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            core_q <= '0;
            bus_q <= '0;
        end else begin
            core_q <= core_d;
            bus_q <= bus_d;
        end
    end

    // ======================================================================
    // Status mirror of the request register
    logic [15:0] latgnt_out_q; // Registered copy for the core

    // Copy follows the assembled value one cycle later
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            latgnt_out_q <= `OHC_LATGNT_RST;
        end else begin
            latgnt_out_q <= latgnt_value;
        end
    end

    // ======================================================================
    // Outputs, all from flip-flops
    assign cfg_rsp = rsp_q;
    assign core_out_quad = core_q;
    assign bus_out_quad = bus_q;
    assign latency_grant_request = latgnt_out_q;
    assign swap_enable = swap_q;
    assign load_open = load_open_q;

endmodule : ohc_cfg_regs

`default_nettype wire

// ===== bench/ohc_cfg_regs_checker.sv
// Purpose: Port-level properties of the config header registers
// Assumes: One clock, reset asynchronous and active high
// Notes:   Bound to ohc_cfg_regs below the module
`default_nettype none

// ==========================================================================
// Checker
module ohc_cfg_regs_checker
    import ohc_cfg_pkg::*;
#(
    parameter int QUAD_W = 32
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic function_reset,
    input wire ohc_cfg_req_s cfg_req,
    input wire ohc_cfg_rsp_s cfg_rsp,
    input wire logic eeprom_present,
    input wire logic ee_load_valid,
    input wire logic [3:0] ee_lat_nibble,
    input wire logic [3:0] ee_gnt_nibble,
    input wire logic ee_load_done,
    input wire ohc_quad_s bus_in_quad,
    input wire ohc_quad_s core_out_quad,
    input wire ohc_quad_s core_in_quad,
    input wire ohc_quad_s bus_out_quad,
    input wire logic [15:0] latency_grant_request,
    input wire logic swap_enable,
    input wire logic load_open
);
    timeunit 1ns;
    timeprecision 1ps;

    // Byte order reversal of one quadlet
    function automatic logic [31:0] rev(input logic [31:0] d);
        return {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction : rev

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // Read of one dword, then its answer
    sequence s_rd(logic [5:0] dw);
        cfg_req.valid && !cfg_req.write && cfg_req.dword == dw ##1 cfg_rsp.ack;
    endsequence

    a_ack_next: assert property (cfg_req.valid |=> cfg_rsp.ack)
        else $error("Request not answered next cycle");
    a_ack_cause: assert property (cfg_rsp.ack |-> $past(cfg_req.valid))
        else $error("Answer without request");
    a_cap_read: assert property (s_rd(6'h11) |-> cfg_rsp.rdata == 32'h0000_0001)
        else $error("Capability header value wrong");
    a_ctrl_rsvd: assert property (s_rd(6'h10) |-> cfg_rsp.rdata[31:1] == 31'h0)
        else $error("Control reserved bits not zero");
    a_swap_write: assert property (cfg_req.valid && cfg_req.write && cfg_req.dword == 6'h10
        && cfg_req.be[0] && !function_reset |=> swap_enable == $past(cfg_req.wdata[0]))
        else $error("Swap bit not written");
    a_swap_clear: assert property (function_reset |=> !swap_enable)
        else $error("Swap bit not cleared");
    a_quad_in: assert property (bus_in_quad.valid |=> core_out_quad.valid
        && core_out_quad.data == ($past(swap_enable) ? rev($past(bus_in_quad.data))
        : $past(bus_in_quad.data)))
        else $error("Inbound quadlet wrong");
    a_quad_out: assert property (core_in_quad.valid |=> bus_out_quad.valid
        && bus_out_quad.data == ($past(swap_enable) ? rev($past(core_in_quad.data))
        : $past(core_in_quad.data)))
        else $error("Outbound quadlet wrong");
    a_lat_upper: assert property (latency_grant_request[15:12] == 4'h0
        && latency_grant_request[7:4] == 4'h0)
        else $error("Fixed request bits changed");
    a_lat_frozen: assert property (!load_open [*2] |=> $stable(latency_grant_request))
        else $error("Request register changed after load window");
    // Releasing edge still samples reset high, so the window closes one edge later
    a_no_eeprom: assert property (!reset && !eeprom_present && load_open |=> !load_open)
        else $error("Load window open without EEPROM");

endmodule : ohc_cfg_regs_checker

bind ohc_cfg_regs ohc_cfg_regs_checker #(.QUAD_W(QUAD_W)) ohc_cfg_regs_checker_inst (
    .mclk(mclk), .reset(reset), .function_reset(function_reset), .cfg_req(cfg_req),
    .cfg_rsp(cfg_rsp), .eeprom_present(eeprom_present), .ee_load_valid(ee_load_valid),
    .ee_lat_nibble(ee_lat_nibble), .ee_gnt_nibble(ee_gnt_nibble),
    .ee_load_done(ee_load_done), .bus_in_quad(bus_in_quad), .core_out_quad(core_out_quad),
    .core_in_quad(core_in_quad), .bus_out_quad(bus_out_quad),
    .latency_grant_request(latency_grant_request), .swap_enable(swap_enable),
    .load_open(load_open));

`default_nettype wire

// ===== bench/ohc_host_model.sv
// Purpose: Host bridge model issuing config accesses
// Assumes: One-cycle request pulse, answer one cycle after it is taken
// Notes:   Idle fields are scrambled so stale values cannot pass
`default_nettype none

// ==========================================================================
// Host model
module ohc_host_model
    import ohc_cfg_pkg::*;
(
    input wire logic mclk,
    output ohc_cfg_req_s cfg_req,
    input wire ohc_cfg_rsp_s cfg_rsp
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet request at start
    initial cfg_req = '0;

    // One access after gap idle cycles
    task automatic xfer(input logic w, input logic [5:0] dw, input logic [3:0] be,
                        input logic [31:0] wd, input int gap, output logic [31:0] rd);
        int n;
        repeat (gap) @(posedge mclk);
        @(posedge mclk);
        cfg_req <= '{1'b1, w, dw, be, wd};
        @(posedge mclk);
        cfg_req <= '{1'b0, ~w, ~dw, ~be, ~wd};
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (cfg_rsp.ack !== 1'b1 && n < 4);
        // Unknown marks a missing answer
        rd = (cfg_rsp.ack === 1'b1) ? cfg_rsp.rdata : {32{1'bx}};
    endtask : xfer

endmodule : ohc_host_model

`default_nettype wire

// ===== bench/test_ohci_config_header_regs.sv
// Purpose: Self-checking bench of the config header registers
// Assumes: Host model drives the config port
// Notes:   Quadlet and EEPROM sides driven here
`default_nettype none

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end

// ==========================================================================
// Bench top
module test_ohci_config_header_regs
    import ohc_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic function_reset = 1'b0;
    logic eeprom_present = 1'b1;
    logic ee_load_valid = 1'b0;
    logic ee_load_done = 1'b0;
    logic [3:0] lat_nib = 4'h0;
    logic [3:0] gnt_nib = 4'h0;
    ohc_quad_s bus_in = '0;
    ohc_quad_s core_in = '0;
    ohc_cfg_req_s cfg_req;
    ohc_cfg_rsp_s cfg_rsp;
    ohc_quad_s core_out;
    ohc_quad_s bus_out;
    logic [15:0] lgr;
    logic swap_en;
    logic load_open;
    int fail_count = 0;
    int tests_run = 0;

    // 125 MHz clock
    always #4 mclk = ~mclk;

    ohc_cfg_regs #(.QUAD_W(32)) ohc_cfg_regs_inst (
        .mclk(mclk), .reset(reset), .function_reset(function_reset), .cfg_req(cfg_req),
        .cfg_rsp(cfg_rsp), .eeprom_present(eeprom_present), .ee_load_valid(ee_load_valid),
        .ee_lat_nibble(lat_nib), .ee_gnt_nibble(gnt_nib), .ee_load_done(ee_load_done),
        .bus_in_quad(bus_in), .core_out_quad(core_out), .core_in_quad(core_in),
        .bus_out_quad(bus_out), .latency_grant_request(lgr), .swap_enable(swap_en),
        .load_open(load_open));

    ohc_host_model ohc_host_model_inst (.mclk(mclk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));

    // Read one dword and compare
    task automatic rd_chk(input logic [5:0] dw, input logic [31:0] e);
        logic [31:0] r;
        ohc_host_model_inst.xfer(1'b0, dw, 4'hf, 32'h0, 0, r);
        `CHK(r, e)
    endtask : rd_chk

    // Write one dword, answer data is zero
    task automatic wr(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] r;
        ohc_host_model_inst.xfer(1'b1, dw, be, d, 1, r);
        `CHK(r, 32'h0)
    endtask : wr

    // One quadlet each way, compare both outputs
    task automatic quad_chk(input logic [31:0] a, input logic sw);
        logic [31:0] e;
        e = sw ? {a[7:0], a[15:8], a[23:16], a[31:24]} : a;
        @(posedge mclk);
        bus_in <= '{1'b1, a};
        core_in <= '{1'b1, ~a};
        @(posedge mclk);
        bus_in <= '{1'b0, ~a};
        core_in <= '{1'b0, a};
        @(negedge mclk);
        `CHK(core_out, {1'b1, e})
        `CHK(bus_out, {1'b1, ~e})
    endtask : quad_chk

    // One EEPROM load pulse, optional closing pulse
    task automatic ee_load(input logic [3:0] l, input logic [3:0] g, input logic done);
        @(posedge mclk);
        ee_load_valid <= 1'b1;
        lat_nib <= l;
        gnt_nib <= g;
        ee_load_done <= done;
        @(posedge mclk);
        ee_load_valid <= 1'b0;
        ee_load_done <= 1'b0;
        lat_nib <= ~l;
        gnt_nib <= ~g;
    endtask : ee_load

    // Line at the end of each test
    task automatic end_test(input string s);
        $display("Test %s done, checks %0d", s, tests_run);
    endtask : end_test

    // Counts, verdict and end of run
    task automatic final_report;
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    // Main sequence
    initial begin
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        ee_load(4'h3, 4'hc, 1'b0);
        ee_load(4'ha, 4'h5, 1'b1);
        ee_load(4'hf, 4'hf, 1'b0);
        rd_chk(6'h0f, 32'h0a05_0000);
        `CHK(lgr, 16'h0a05)
        end_test("load");
        wr(6'h0f, 4'hf, 32'hffff_ffff);
        wr(6'h11, 4'hf, 32'hffff_ffff);
        rd_chk(6'h0f, 32'h0a05_0000);
        rd_chk(6'h11, 32'h0000_0001);
        rd_chk(6'h20, 32'h0);
        end_test("fixed");
        rd_chk(6'h10, 32'h0);
        quad_chk(32'h1122_3344, 1'b0);
        wr(6'h10, 4'hf, 32'hffff_ffff);
        rd_chk(6'h10, 32'h1);
        wr(6'h10, 4'he, 32'h0);
        rd_chk(6'h10, 32'h1);
        quad_chk(32'h1122_3344, 1'b1);
        quad_chk(32'ha1b2_c3d4, 1'b1);
        end_test("swap");
        @(posedge mclk);
        function_reset <= 1'b1;
        @(posedge mclk);
        function_reset <= 1'b0;
        rd_chk(6'h10, 32'h0);
        rd_chk(6'h0f, 32'h0a05_0000);
        end_test("lesser reset");
        @(posedge mclk);
        reset <= 1'b1;
        eeprom_present <= 1'b0;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        ee_load(4'ha, 4'h5, 1'b0);
        rd_chk(6'h0f, 32'h0402_0000);
        `CHK(lgr, 16'h0402)
        end_test("no eeprom");
        final_report;
    end

    // Watchdog against a hang
    initial begin
        repeat (3000) @(posedge mclk);
        fail_count++;
        final_report;
    end

endmodule : test_ohci_config_header_regs

`default_nettype wire
